// [design/pic_pkg.sv]
package pic_pkg;

    // Register byte addresses (word aligned)
    localparam logic [4:0] ADDR_PRIO_A   = 5'h00;
    localparam logic [4:0] ADDR_PRIO_B   = 5'h04;
    localparam logic [4:0] ADDR_PRIO_C   = 5'h08;
    localparam logic [4:0] ADDR_PRIO_D   = 5'h0C;
    localparam logic [4:0] ADDR_PRIO_E   = 5'h10;
    localparam logic [4:0] ADDR_SENSE    = 5'h14;
    localparam logic [4:0] ADDR_STATUS   = 5'h18;

    localparam int         PRIO_REGS     = 5;
    localparam logic [15:0] PRIO_RESET   = 16'h0000;
    localparam logic [15:0] PRIO_E_MASK  = 16'hFFF0;
    localparam logic [15:0] SENSE_RESET  = 16'h0000;
    localparam logic [15:0] SENSE_WMASK  = 16'h01FF;
    localparam int          SENSE_NONMASKABLE_PIN_LEVEL   = 15;
    localparam int          SENSE_NONMASKABLE_EDGE_SELECT   = 8;

    localparam logic [1:0] RESP_OKAY     = 2'b00;
    localparam logic [1:0] RESP_SLVERR   = 2'b10;

    // Source count: 8 pins, 22 on-chip requests
    localparam int         NUM_PINS      = 8;
    localparam int         NUM_ONCHIP    = 22;
    localparam int         NUM_SRC       = NUM_PINS + NUM_ONCHIP;
    localparam logic [4:0] SRC_NONE      = 5'h1F;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } pic_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } pic_axi_rsp_s;

    typedef struct packed {
        logic       req;
        logic [3:0] level;
        logic [4:0] source;
        logic       nmi;
    } pic_cpu_req_s;

endpackage : pic_pkg

// [design/pic_top.sv]
// How it works
// - Five sixteen bit read/write priority registers
// - Four nibble fields of A to D map pins and groups
// - Nibble zero lowest, all ones highest
// - Shared field gives both modules same level
// - Reset clears priorities; standby keeps them
// - Last register low nibble reads zero
// - Bit 15 shows nonmaskable pin level
// - Bits 14 to 9 read zero
// - Bit 8 picks nonmaskable edge
// - Bits 7..0 pick pin level/edge sensing
// - Reset initialises control; standby keeps it
// - Highest level wins; fixed order breaks ties
// - Signal only if level exceeds cpu mask
// - Request out pin low while request is signalled
// - Cpu takes request at next decode
// - Cpu pushes status and pc first
// - Accepted level copied into cpu mask
// - Level/on-chip: out pin high after acceptance
// - Edge: pin high at replace, unless higher; the code raises it for a cycle after any maskable acceptance unless a nonmaskable edge comes in that cycle
// - Cpu fetches vector, branches undelayed
// - Edge latched once; level only while held
// - On-chip requests are levels until cleared
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
module pic_top
    import pic_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire pic_axi_req_s          axiReq,
    output pic_axi_rsp_s               axiRsp,
    input  wire logic [NUM_PINS-1:0]   extPinN,
    input  wire logic                  nmiPin,
    input  wire logic [NUM_ONCHIP-1:0] onchipReq,
    input  wire logic [3:0]            cpu_mask_level,
    input  wire logic                  cpuAck,
    output pic_cpu_req_s               cpuReq,
    output logic                       request_out_pinN
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [2:0]                 rstSync;
        logic [NUM_PINS-1:0]        pinMeta;
        logic [NUM_PINS-1:0]        pinSync;
        logic [NUM_PINS-1:0]        pinPrev;
        logic                       nmiMeta;
        logic                       nmiSync;
        logic                       nmiPrev;
        logic [NUM_PINS-1:0]        edgePend;
        logic                       nmiPend;
        logic [PRIO_REGS-1:0][15:0] prio;
        logic [15:0]                sense;
        logic                       awHave;
        logic [4:0]                 awAddr;
        logic                       wHave;
        logic [31:0]                wData;
        logic [3:0]                 wStrb;
        pic_axi_rsp_s               rsp;
        pic_cpu_req_s               cpu;
        logic                       outN;
    } pic_state_s;

    pic_state_s st_r;
    pic_state_s st_nxt;

    // Reset released through two flops; rstSync[0] is the first stage, rstSync[1] the output
    logic rstn;
    assign rstn = st_r.rstSync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Source levels and pending requests

    logic [NUM_SRC-1:0]        pend;
    logic [NUM_SRC-1:0][3:0]   srcLvl;
    logic                      winValid;
    logic [3:0]                winLvl;
    logic [4:0]                winSrc;
    logic [4:0]                i5;

    always_comb begin
        // Pins 0..7: register A then B, high nibble first
        for (int p = 0; p < NUM_PINS; p++) begin
            srcLvl[p] = st_r.prio[p/4][15-4*(p%4) -: 4];
            // Level-sensed pending only while low; edge uses latch
            pend[p] = st_r.sense[7-p] ? st_r.edgePend[p] : ~st_r.pinSync[p];
        end
        // On-chip order: dma0..3, timer0..4 x3, serial0 x3
        for (int q = 0; q < NUM_ONCHIP; q++) begin
            pend[NUM_PINS+q] = onchipReq[q];
        end
        srcLvl[8]  = st_r.prio[2][15:12]; // Shared field
        srcLvl[9]  = st_r.prio[2][15:12];
        srcLvl[10] = st_r.prio[2][11:8];
        srcLvl[11] = st_r.prio[2][11:8];
        srcLvl[12] = st_r.prio[2][7:4];
        srcLvl[13] = st_r.prio[2][3:0];
        srcLvl[14] = st_r.prio[3][15:12];
        srcLvl[15] = st_r.prio[3][11:8];
        srcLvl[16] = st_r.prio[3][7:4];
        srcLvl[17] = st_r.prio[3][3:0];
        srcLvl[18] = st_r.prio[4][15:12];
        srcLvl[19] = st_r.prio[4][11:8];
        srcLvl[20] = st_r.prio[4][11:8];
        srcLvl[21] = st_r.prio[4][7:4];
        srcLvl[22] = st_r.prio[4][7:4];
        for (int q = 23; q < NUM_SRC; q++) begin
            srcLvl[q] = 4'h0;
        end
        // Timer slots 12..26: three per timer, five timers
        for (int q = 0; q < 15; q++) begin
            srcLvl[12+q] = (q < 3)  ? st_r.prio[2][7:4]   :
                           (q < 6)  ? st_r.prio[2][3:0]   :
                           (q < 9)  ? st_r.prio[3][15:12] :
                           (q < 12) ? st_r.prio[3][11:8]  : st_r.prio[3][7:4];
        end
        // Serial0 fills the last three slots; serial1 has no index here
        for (int q = 0; q < 3; q++) begin
            srcLvl[27+q] = st_r.prio[3][3:0];
        end
    end

    // Index map after the loops above:
    // 0..7 pins, 8..11 dma, 12..26 timers, 27..29 serial0 (first three)
    // Only 30 sources exist, so serial0 carries three and serial1 has no slot.
    // Lower index wins ties: fixed default order
    always_comb begin
        winValid = 1'b0;
        winLvl   = 4'h0;
        winSrc   = SRC_NONE;
        i5       = 5'h00;
        for (int s = 0; s < NUM_SRC; s++) begin
            i5 = 5'(s);
            if (pend[s] && (!winValid || srcLvl[s] > winLvl)) begin
                winValid = 1'b1;
                winLvl   = srcLvl[s];
                winSrc   = i5;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic        wrFire;
    logic        rdFire;
    logic [15:0] wr16;
    logic [15:0] rdVal;
    logic        rdHit;
    logic        wrHit;
    logic        accept;
    logic        nmiEdge;
    logic        takeNmi;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rstSync = {st_r.rstSync[1:0], 1'b1};

        // Two-flop synchronisers; first stage read only by second
        st_nxt.pinMeta = extPinN;
        st_nxt.pinSync = st_r.pinMeta;
        st_nxt.pinPrev = st_r.pinSync;
        st_nxt.nmiMeta = nmiPin;
        st_nxt.nmiSync = st_r.nmiMeta;
        st_nxt.nmiPrev = st_r.nmiSync;

        // Nonmaskable edge by polarity
        nmiEdge = st_r.sense[SENSE_NONMASKABLE_EDGE_SELECT] ? (st_r.nmiSync & ~st_r.nmiPrev)
                                         : (~st_r.nmiSync & st_r.nmiPrev);

        // Cpu handshake: ack marks replace of the decoded instruction
        accept  = st_r.cpu.req && cpuAck;
        takeNmi = accept && st_r.cpu.nmi;

        // Edge latches: clear on acceptance, set wins over clear
        for (int p = 0; p < NUM_PINS; p++) begin
            if (accept && !st_r.cpu.nmi && st_r.cpu.source == 5'(p)) begin
                st_nxt.edgePend[p] = 1'b0;
            end
            if (st_r.sense[7-p] && !st_r.pinSync[p] && st_r.pinPrev[p]) begin
                st_nxt.edgePend[p] = 1'b1;
            end
            if (!st_r.sense[7-p]) begin
                st_nxt.edgePend[p] = 1'b0;
            end
        end
        if (takeNmi) begin
            st_nxt.nmiPend = 1'b0;
        end
        if (nmiEdge) begin
            st_nxt.nmiPend = 1'b1;
        end

        // Request to cpu re-evaluated every cycle; masked stays pending
        // Cpu itself pushes status/pc, loads mask, vectors
        if (st_nxt.nmiPend) begin
            st_nxt.cpu = '{req: 1'b1, level: 4'hF, source: SRC_NONE, nmi: 1'b1};
        end else if (winValid && winLvl > cpu_mask_level && !accept) begin
            st_nxt.cpu = '{req: 1'b1, level: winLvl, source: winSrc, nmi: 1'b0};
        end else begin
            st_nxt.cpu = '{req: 1'b0, level: 4'h0, source: SRC_NONE, nmi: 1'b0};
        end
        // Inverse of the cpu request, same timing; released after acceptance
        st_nxt.outN = ~st_nxt.cpu.req;

        // AXI write: address and data taken in either order
        if (axiReq.awvalid && st_r.rsp.awready) begin
            st_nxt.awHave = 1'b1;
            st_nxt.awAddr = axiReq.awaddr[4:0];
        end
        if (axiReq.wvalid && st_r.rsp.wready) begin
            st_nxt.wHave = 1'b1;
            st_nxt.wData = axiReq.wdata;
            st_nxt.wStrb = axiReq.wstrb;
        end
        st_nxt.rsp.awready = !st_nxt.awHave && !st_r.rsp.bvalid;
        st_nxt.rsp.wready  = !st_nxt.wHave && !st_r.rsp.bvalid;

        wrFire = st_r.awHave && st_r.wHave && !st_r.rsp.bvalid;
        wrHit  = 1'b0;
        wr16   = 16'h0000;
        for (int r = 0; r < PRIO_REGS; r++) begin
            if (wrFire && st_r.awAddr == 5'(4*r)) begin
                wrHit = 1'b1;
                wr16 = st_r.prio[r];
                if (st_r.wStrb[0]) wr16[7:0] = st_r.wData[7:0];
                if (st_r.wStrb[1]) wr16[15:8] = st_r.wData[15:8];
                // Reserved nibble forced to zero
                st_nxt.prio[r] = (r == PRIO_REGS-1) ? (wr16 & PRIO_E_MASK) : wr16;
            end
        end
        if (wrFire && st_r.awAddr == ADDR_SENSE) begin
            wrHit = 1'b1;
            wr16 = st_r.sense;
            if (st_r.wStrb[0]) wr16[7:0] = st_r.wData[7:0];
            if (st_r.wStrb[1]) wr16[15:8] = st_r.wData[15:8];
            st_nxt.sense = wr16 & SENSE_WMASK;
        end
        if (wrFire) begin
            st_nxt.awHave = 1'b0;
            st_nxt.wHave  = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp  = wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (st_r.rsp.bvalid && axiReq.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
        end

        // AXI read
        rdHit = 1'b1;
        rdVal = 16'h0000;
        unique case (axiReq.araddr[4:0])
            ADDR_PRIO_A: rdVal = st_r.prio[0];
            ADDR_PRIO_B: rdVal = st_r.prio[1];
            ADDR_PRIO_C: rdVal = st_r.prio[2];
            ADDR_PRIO_D: rdVal = st_r.prio[3];
            ADDR_PRIO_E: rdVal = st_r.prio[4] & PRIO_E_MASK;
            ADDR_SENSE:  rdVal = {st_r.nmiSync, 6'h00, st_r.sense[8:0]};
            ADDR_STATUS: rdVal = {st_r.cpu.req, st_r.cpu.nmi, 1'b0, st_r.cpu.source,
                                  st_r.cpu.level, st_r.nmiPend, 3'h0};
            default:     rdHit = 1'b0;
        endcase
        if (axiReq.araddr[31:5] != 27'h0 || axiReq.araddr[1:0] != 2'h0) begin
            rdHit = 1'b0;
        end
        rdFire = axiReq.arvalid && st_r.rsp.arready;
        if (rdFire) begin
            st_nxt.rsp.rvalid  = 1'b1;
            st_nxt.rsp.rdata   = {16'h0000, rdVal};
            st_nxt.rsp.rresp   = rdHit ? RESP_OKAY : RESP_SLVERR;
            st_nxt.rsp.arready = 1'b0;
        end else if (st_r.rsp.rvalid && axiReq.rready) begin
            st_nxt.rsp.rvalid  = 1'b0;
            st_nxt.rsp.arready = 1'b1;
        end
        // Address ready whenever no read answer is waiting
        st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r            <= '0;
            st_r.outN       <= 1'b1;
            st_r.pinMeta    <= '1;
            st_r.pinSync    <= '1;
            st_r.pinPrev    <= '1;
            st_r.cpu.source <= SRC_NONE;
        end else if (!rstn) begin
            st_r          <= '0;
            st_r.rstSync  <= st_nxt.rstSync;
            st_r.prio     <= '{default: PRIO_RESET};
            st_r.sense    <= SENSE_RESET;
            st_r.outN     <= 1'b1;
            st_r.pinMeta  <= '1;
            st_r.pinSync  <= '1;
            st_r.pinPrev  <= '1;
            st_r.cpu.source <= SRC_NONE;
            st_r.nmiMeta  <= nmiPin;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign axiRsp           = st_r.rsp;
    assign cpuReq           = st_r.cpu;
    assign request_out_pinN = st_r.outN;

endmodule : pic_top

// [verif/pic_chk.sv]
module pic_chk
    import pic_pkg::*;
(
    input wire logic                  ref_clk,
    input wire logic                  resetn,
    input wire pic_axi_req_s          axiReq,
    input wire pic_axi_rsp_s          axiRsp,
    input wire logic [NUM_PINS-1:0]   extPinN,
    input wire logic                  nmiPin,
    input wire logic [NUM_ONCHIP-1:0] onchipReq,
    input wire logic [3:0]            cpu_mask_level,
    input wire logic                  cpuAck,
    input wire pic_cpu_req_s          cpuReq,
    input wire logic                  request_out_pinN
);
    timeunit 1ns;
    timeprecision 1ns;
    // Request flags as the arbiter saw them one edge ago
    logic [NUM_ONCHIP-1:0] onPrev_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            onPrev_r <= '0;
        end else begin
            onPrev_r <= onchipReq;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    out_pin_a: assert property (request_out_pinN == !cpuReq.req)
        else $error("request out pin differs from cpu request");
    mask_gate_a: assert property (cpuReq.req && !cpuReq.nmi |-> cpuReq.level > $past(cpu_mask_level))
        else $error("request signalled at or below mask");
    ack_drop_a: assert property (cpuAck && cpuReq.req |=> !cpuReq.req)
        else $error("request still high after acceptance");
    src_pending_a: assert property (cpuReq.req && cpuReq.source inside {[5'h08:5'h1D]}
        |-> onPrev_r[cpuReq.source - 5'h08])
        else $error("signalled source has no request");
    nmi_src_a: assert property (cpuReq.req && cpuReq.nmi |-> cpuReq.source == SRC_NONE)
        else $error("nonmaskable request with wrong source");
    rd_answer_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
        else $error("read answer late");
    ar_block_a: assert property (axiRsp.rvalid |-> !axiRsp.arready)
        else $error("read address taken while answer pending");
    wr_answer_a: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
        && axiRsp.wready |-> ##[1:3] axiRsp.bvalid)
        else $error("write answer late");
endmodule : pic_chk

// [verif/pic_cpu_model.sv]
module pic_cpu_model
    import pic_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [2:0]   ackDelay,
    input  wire pic_cpu_req_s cpuReq,
    output logic              cpuAck
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_r;

    // Accepts at a later decode; one-cycle pulse that can still fall on a request dropped at the same edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wait_r <= 3'h0;
            cpuAck <= 1'b0;
        end else if (cpuAck) begin
            wait_r <= 3'h0;
            cpuAck <= 1'b0;
        end else if (cpuReq.req) begin
            if (wait_r >= ackDelay) cpuAck <= 1'b1;
            else wait_r <= wait_r + 3'h1;
        end else begin
            wait_r <= 3'h0;
        end
    end
endmodule : pic_cpu_model

// [verif/test_pic_top.sv]
module test_pic_top
    import pic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         ref_clk = 1'b0;
    logic         resetn = 1'b0;
    pic_axi_req_s axiReq = '0;
    pic_axi_rsp_s axiRsp;
    logic [7:0]   extPinN = 8'hFF;
    logic         nmiPin = 1'b1;
    logic [21:0]  onchipReq = '0;
    logic [3:0]   cpu_mask_level = 4'h4;
    logic [2:0]   ackDelay = 3'h4;
    logic         cpuAck;
    pic_cpu_req_s cpuReq;
    logic         request_out_pinN;
    logic [33:0]  axQ[$];
    logic [8:0]   cpuQ[$];
    int           mismatches = 0;
    int           total_checks = 0;
    int           seed = 86210;
    int           cycles = 0;
    logic [15:0]  d;

    always #25 ref_clk = ~ref_clk;

    pic_top pic_top_i (.*);
    pic_cpu_model pic_cpu_model_i (.*);

    ////////////////////////////////////////////////////////////////
    task automatic check(string n, logic [33:0] seen, logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic end_sim;
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic wr(logic [4:0] a, logic [15:0] v, logic [1:0] r);
        @(posedge ref_clk);
        axQ.push_back({r, 32'h0});
        axiReq.awaddr <= {27'h0, a};
        axiReq.wdata <= {16'h0, v};
        axiReq.wstrb <= 4'h3;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready) axiReq.wvalid <= 1'b0;
        end while (!axiRsp.bvalid);
        axiReq.bready <= 1'b0;
    endtask : wr

    task automatic rd(logic [4:0] a, logic [15:0] v);
        @(posedge ref_clk);
        axQ.push_back({RESP_OKAY, 16'h0, v});
        axiReq.araddr <= {27'h0, a};
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        do @(posedge ref_clk); while (!axiRsp.arready);
        axiReq.arvalid <= 1'b0;
        do @(posedge ref_clk); while (!axiRsp.rvalid);
        axiReq.rready <= 1'b0;
    endtask : rd

    // Slow acks only: a level source lingers a few cycles after its flag clears
    task automatic serve(logic [3:0] lv, logic [4:0] src);
        cpuQ.push_back({lv, src});
        ackDelay <= 3'($random(seed)) | 3'h4;
        do @(posedge ref_clk); while (!(cpuAck && cpuReq.req));
    endtask : serve

    ////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (axiRsp.bvalid && axiReq.bready) check("bresp", {axiRsp.bresp, 32'h0}, axQ.pop_front());
        if (axiRsp.rvalid && axiReq.rready) check("rdata", {axiRsp.rresp, axiRsp.rdata}, axQ.pop_front());
        if (cpuAck && cpuReq.req) check("cpu", {25'h0, cpuReq.level, cpuReq.source}, {25'h0, cpuQ.pop_front()});
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < 5; i++) rd(5'(i * 4), PRIO_RESET);
        rd(ADDR_SENSE, 16'h8000);
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed));
            wr(5'(i * 4), d, RESP_OKAY);
            rd(5'(i * 4), d);
        end
        wr(ADDR_PRIO_E, 16'hFFFF, RESP_OKAY);
        rd(ADDR_PRIO_E, 16'hFFF0);
        wr(5'h1C, 16'hFFFF, RESP_SLVERR);
        wr(ADDR_SENSE, 16'hFFFF, RESP_OKAY);
        rd(ADDR_SENSE, 16'h81FF);
        // Rising-edge select set first, so this fall raises nothing
        nmiPin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(ADDR_SENSE, 16'h01FF);
        wr(ADDR_PRIO_C, 16'h5A00, RESP_OKAY);
        onchipReq <= 22'h7;
        serve(4'hA, 5'd10);
        onchipReq <= 22'h3;
        serve(4'h5, 5'd8);
        onchipReq <= 22'h2;
        serve(4'h5, 5'd9);
        cpu_mask_level <= 4'h5;
        onchipReq <= 22'h1;
        repeat (8) @(posedge ref_clk);
        check("masked", {33'h0, cpuReq.req}, 34'h0);
        cpu_mask_level <= 4'h4;
        serve(4'h5, 5'd8);
        onchipReq <= 22'h0;
        wr(ADDR_PRIO_A, 16'h0F00, RESP_OKAY);
        extPinN[1] <= 1'b0;
        repeat (3) @(posedge ref_clk);
        extPinN[1] <= 1'b1;
        serve(4'hF, 5'd1);
        repeat (8) @(posedge ref_clk);
        check("edge once", {33'h0, cpuReq.req}, 34'h0);
        wr(ADDR_SENSE, 16'h0100, RESP_OKAY);
        extPinN[1] <= 1'b0;
        serve(4'hF, 5'd1);
        extPinN[1] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        // Rising edge selected by the last control write
        nmiPin <= 1'b1;
        serve(4'hF, SRC_NONE);
        cpu_mask_level <= 4'hF;
        extPinN[1] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        extPinN[1] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cpu_mask_level <= 4'h4;
        repeat (8) @(posedge ref_clk);
        check("withdrawn", {33'h0, cpuReq.req}, 34'h0);
        rd(ADDR_STATUS, 16'h1F00);
        end_sim();
    end
endmodule : test_pic_top

bind pic_top pic_chk pic_chk_i (.*);
